/* shared/sq_pkg.sv */
// constants, register map and types for the serial control port and transmitter gating
package sq_pkg;
    // seven-bit target address: fixed upper part, two strap bits below
    localparam logic [4:0] ADDR_FIXED = 5'h12;
    localparam int ADDR_SEL_W = 2;

    // register pointers
    localparam logic [7:0] OFS_LOS_A = 8'h1F;
    localparam logic [7:0] OFS_LOS_B = 8'h3F;
    localparam logic [7:0] OFS_CFG_A = 8'hC0;
    localparam logic [7:0] OFS_SQ_A = 8'hC3;
    localparam logic [7:0] OFS_CFG_B = 8'hE0;
    localparam logic [7:0] OFS_SQ_B = 8'hE3;

    // field positions and reset values
    localparam int CFG_EN_BIT = 4;
    localparam logic [7:0] SQ_RESET = 8'hFF;
    localparam logic [7:0] CFG_RESET = 8'h10;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // synchroniser idle levels: scl, sda high; straps and loss flags low
    localparam logic [11:0] SYNC_RESET = 12'hC00;

    // transmitter re-enable time after full power-down
    localparam int CLK_PERIOD_NS = 10;
    localparam int REENABLE_NS = 1000;
    localparam int REENABLE_CYC = (REENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h2,
        ST_PTR = 4'h3,
        ST_PACK = 4'h4,
        ST_WDAT = 4'h5,
        ST_WACK = 4'h6,
        ST_RDAT = 4'h7,
        ST_RACK = 4'h8,
        ST_SKIP = 4'h9
    } link_state_type;
endpackage

/* shared/tx_ctrl_if.sv */
// carrier between register logic and transmitter power sequencer
`timescale 1ns/10ps
interface tx_ctrl_if;
    logic [7:0] power_req;
    logic [7:0] squelch_req;
    logic [7:0] powered;
    logic [7:0] current_on;

    modport ctrl (
        output power_req,
        output squelch_req,
        input powered,
        input current_on
    );
    modport seq (
        input power_req,
        input squelch_req,
        output powered,
        output current_on
    );
endinterface

/* rtl/sync2.sv */
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module sync2 #(
    parameter int WIDTH = 12,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= RESET_VAL;
            q_ff <= RESET_VAL;
        end
        else
        begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule // sync2

/* rtl/tx_power_seq.sv */
// per-channel transmitter power and output current sequencing
`timescale 1ns/10ps
module tx_power_seq #(
    parameter int CHANNELS = 8,
    parameter int REENABLE_CYC = sq_pkg::REENABLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    tx_ctrl_if.seq tx
);
    localparam int CW = $clog2(REENABLE_CYC + 1);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_ch
            logic [CW-1:0] wait_ff;
            logic powered_ff;
            logic on_ff;

            // disable is a full power-down; coming back waits out the bias settling time
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    wait_ff <= '0;
                    powered_ff <= 1'b0;
                end
                else if (!tx.power_req[i])
                begin
                    wait_ff <= '0;
                    powered_ff <= 1'b0;
                end
                else if (!powered_ff)
                begin
                    if (wait_ff == CW'(REENABLE_CYC - 1))
                        powered_ff <= 1'b1;
                    else
                        wait_ff <= wait_ff + CW'(1);
                end
            end

            // squelch only gates the current, so it returns on the next edge
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    on_ff <= 1'b0;
                else
                    on_ff <= tx.power_req[i] & powered_ff & ~tx.squelch_req[i];
            end

            assign tx.powered[i] = powered_ff;
            assign tx.current_on[i] = on_ff;

            reenable_wait_a: assert property ($rose(tx.power_req[i]) |=> !tx.current_on[i] [*8])
                else $error("current resumed too soon after re-enable");
            squelch_zero_a: assert property (tx.squelch_req[i] |=> !tx.current_on[i])
                else $error("current flows while squelched");
            squelch_fast_a: assert property (
                $fell(tx.squelch_req[i]) && tx.powered[i] && tx.power_req[i] |=> tx.current_on[i])
                else $error("current slow to return after squelch release");
        end
    endgenerate
endmodule // tx_power_seq

/* rtl/i2c_slave_tx_squelch_ctrl.sv */
// two-wire target port with transmitter squelch and disable registers
`timescale 1ns/10ps
module i2c_slave_tx_squelch_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [sq_pkg::ADDR_SEL_W-1:0] addr_sel,
    input wire logic [7:0] signal_loss_flag,
    output logic [7:0] tx_powered,
    output logic [7:0] tx_current_on
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // an all-zero nibble is the only code that activates squelch or disable
    function automatic logic nibble_zero(input logic [3:0] n);
        return n == 4'h0;
    endfunction

    logic [11:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic [1:0] addr_sel_s;
    logic [7:0] loss_s;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    sq_pkg::link_state_type state_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] rd_shift_ff;
    logic [7:0] ptr_ff;
    logic [7:0] wdata_ff;
    logic rw_ff;
    logic mack_ff;
    logic commit_ff;
    logic sda_oe_ff;
    logic sda_out_ff;
    logic addr_match;

    logic [7:0] sq_a_ff;
    logic [7:0] sq_b_ff;
    logic [7:0] cfg_a_ff;
    logic [7:0] cfg_b_ff;
    logic [7:0] los_hist_ff;
    logic [7:0] rd_val;

    tx_ctrl_if tx ();

    // the bus is far slower than ref_clk, so both lines are oversampled
    sync2 #(
        .WIDTH(12),
        .RESET_VAL(sq_pkg::SYNC_RESET)
    ) u_sync (
        .clk(ref_clk),
        .rst(rst),
        .d({scl_in, sda_in, addr_sel, signal_loss_flag}),
        .q(sync_q)
    );

    assign scl_s = sync_q[11];
    assign sda_s = sync_q[10];
    assign addr_sel_s = sync_q[9:8];
    assign loss_s = sync_q[7:0];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // scl is only ever sampled; there is no driver for it
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign addr_match = shift_ff[7:1] == {sq_pkg::ADDR_FIXED, addr_sel_s};

    always_comb
    begin
        unique case (ptr_ff)
            sq_pkg::OFS_LOS_A: rd_val = {los_hist_ff[3:0], loss_s[3:0]};
            sq_pkg::OFS_LOS_B: rd_val = {los_hist_ff[7:4], loss_s[7:4]};
            sq_pkg::OFS_CFG_A: rd_val = cfg_a_ff;
            sq_pkg::OFS_SQ_A: rd_val = sq_a_ff;
            sq_pkg::OFS_CFG_B: rd_val = cfg_b_ff;
            sq_pkg::OFS_SQ_B: rd_val = sq_b_ff;
            default: rd_val = sq_pkg::UNMAPPED_READ;
        endcase
    end

    // link engine: bits sampled on scl rise, sda changed only after scl fall
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= sq_pkg::ST_IDLE;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            rd_shift_ff <= 8'h00;
            ptr_ff <= sq_pkg::PTR_RESET;
            wdata_ff <= 8'h00;
            rw_ff <= 1'b0;
            mack_ff <= 1'b0;
            commit_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end
        else
        begin
            commit_ff <= 1'b0;
            if (start_det)
            begin
                // a repeated start always begins a fresh address byte
                state_ff <= sq_pkg::ST_ADDR;
                cnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
            end
            else if (stop_det)
            begin
                state_ff <= sq_pkg::ST_IDLE;
                sda_oe_ff <= 1'b0;
            end
            else
            begin
                unique case (state_ff)
                    sq_pkg::ST_IDLE, sq_pkg::ST_SKIP:
                    begin
                        sda_oe_ff <= 1'b0;
                    end
                    sq_pkg::ST_ADDR, sq_pkg::ST_PTR, sq_pkg::ST_WDAT:
                    begin
                        if (scl_rise)
                        begin
                            shift_ff <= {shift_ff[6:0], sda_s};
                            cnt_ff <= cnt_ff + 4'h1;
                        end
                        else if (scl_fall && cnt_ff == 4'h8)
                        begin
                            cnt_ff <= 4'h0;
                            if (state_ff == sq_pkg::ST_ADDR)
                            begin
                                if (addr_match)
                                begin
                                    rw_ff <= shift_ff[0];
                                    sda_oe_ff <= 1'b1;
                                    state_ff <= sq_pkg::ST_AACK;
                                end
                                else
                                    state_ff <= sq_pkg::ST_SKIP;
                            end
                            else if (state_ff == sq_pkg::ST_PTR)
                            begin
                                sda_oe_ff <= 1'b1;
                                state_ff <= sq_pkg::ST_PACK;
                            end
                            else
                            begin
                                wdata_ff <= shift_ff;
                                sda_oe_ff <= 1'b1;
                                state_ff <= sq_pkg::ST_WACK;
                            end
                        end
                    end
                    sq_pkg::ST_AACK:
                    begin
                        if (scl_fall)
                        begin
                            if (rw_ff)
                            begin
                                rd_shift_ff <= rd_val;
                                sda_oe_ff <= ~rd_val[7];
                                state_ff <= sq_pkg::ST_RDAT;
                            end
                            else
                            begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= sq_pkg::ST_PTR;
                            end
                        end
                    end
                    sq_pkg::ST_PACK:
                    begin
                        if (scl_fall)
                        begin
                            ptr_ff <= shift_ff;
                            sda_oe_ff <= 1'b0;
                            state_ff <= sq_pkg::ST_WDAT;
                        end
                    end
                    sq_pkg::ST_WACK:
                    begin
                        // the store waits for the ack clock to finish; a stop or start earlier drops the byte
                        if (scl_fall)
                        begin
                            commit_ff <= 1'b1;
                            sda_oe_ff <= 1'b0;
                            state_ff <= sq_pkg::ST_SKIP;
                        end
                    end
                    sq_pkg::ST_RDAT:
                    begin
                        if (scl_rise)
                            cnt_ff <= cnt_ff + 4'h1;
                        else if (scl_fall)
                        begin
                            if (cnt_ff == 4'h8)
                            begin
                                cnt_ff <= 4'h0;
                                sda_oe_ff <= 1'b0;
                                state_ff <= sq_pkg::ST_RACK;
                            end
                            else
                            begin
                                rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
                                sda_oe_ff <= ~rd_shift_ff[6];
                            end
                        end
                    end
                    sq_pkg::ST_RACK:
                    begin
                        if (scl_rise)
                            mack_ff <= ~sda_s;
                        else if (scl_fall)
                        begin
                            // no auto-increment: an acked byte is followed by the same register again
                            if (mack_ff)
                            begin
                                rd_shift_ff <= rd_val;
                                sda_oe_ff <= ~rd_val[7];
                                state_ff <= sq_pkg::ST_RDAT;
                            end
                            else
                                state_ff <= sq_pkg::ST_SKIP;
                        end
                    end
                    default:
                    begin
                        state_ff <= sq_pkg::ST_IDLE;
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open drain: the pad is only ever pulled low
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            sda_out_ff <= 1'b0;
        else
            sda_out_ff <= 1'b0;
    end

    // configuration and squelch registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sq_a_ff <= sq_pkg::SQ_RESET;
            sq_b_ff <= sq_pkg::SQ_RESET;
            cfg_a_ff <= sq_pkg::CFG_RESET;
            cfg_b_ff <= sq_pkg::CFG_RESET;
        end
        else if (commit_ff)
        begin
            unique case (ptr_ff)
                sq_pkg::OFS_SQ_A: sq_a_ff <= wdata_ff;
                sq_pkg::OFS_SQ_B: sq_b_ff <= wdata_ff;
                sq_pkg::OFS_CFG_A: cfg_a_ff <= wdata_ff;
                sq_pkg::OFS_CFG_B: cfg_b_ff <= wdata_ff;
                default:
                begin
                    sq_a_ff <= sq_a_ff;
                end
            endcase
        end
    end

    // loss history: a new loss event wins over a clearing write in the same cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            los_hist_ff <= 8'h00;
        else if (commit_ff && ptr_ff == sq_pkg::OFS_LOS_A)
            los_hist_ff <= {los_hist_ff[7:4], los_hist_ff[3:0] & wdata_ff[7:4]} | loss_s;
        else if (commit_ff && ptr_ff == sq_pkg::OFS_LOS_B)
            los_hist_ff <= {los_hist_ff[7:4] & wdata_ff[7:4], los_hist_ff[3:0]} | loss_s;
        else
            los_hist_ff <= los_hist_ff | loss_s;
    end

    // port A drives channels 3:0, port B channels 7:4
    assign tx.power_req = {{4{~nibble_zero(sq_b_ff[3:0]) & cfg_b_ff[sq_pkg::CFG_EN_BIT]}},
                           {4{~nibble_zero(sq_a_ff[3:0]) & cfg_a_ff[sq_pkg::CFG_EN_BIT]}}};
    assign tx.squelch_req = {{4{nibble_zero(sq_b_ff[7:4])}}, {4{nibble_zero(sq_a_ff[7:4])}}};

    tx_power_seq #(
        .CHANNELS(8),
        .REENABLE_CYC(sq_pkg::REENABLE_CYC)
    ) u_seq (
        .ref_clk(ref_clk),
        .rst(rst),
        .tx(tx)
    );

    assign sda_out = sda_out_ff;
    assign sda_oe = sda_oe_ff;
    assign tx_powered = tx.powered;
    assign tx_current_on = tx.current_on;

    sda_low_only_a: assert property (!sda_out_ff)
        else $error("data pin driven high");
    addr_ack_match_a: assert property ($rose(sda_oe_ff) && state_ff == sq_pkg::ST_AACK |-> $past(addr_match))
        else $error("acknowledged a foreign address");
    ptr_retained_a: assert property (!(state_ff == sq_pkg::ST_PACK && scl_fall) |=> $stable(ptr_ff))
        else $error("pointer changed outside a write header");
    read_msb_first_a: assert property (
        state_ff == sq_pkg::ST_AACK && scl_fall && rw_ff && !start_det && !stop_det |=> sda_oe_ff == ~$past(rd_val[7]))
        else $error("read byte does not start with its top bit");
    reset_enable_a: assert property ($past(rst) |-> sq_a_ff == 8'hFF && sq_b_ff == 8'hFF)
        else $error("squelch register not all ones after reset");
    // the enable bit may still power the port down, so only an enabled port must stay powered while squelched
    squelch_a_port_a: assert property (sq_a_ff == 8'h0F && cfg_a_ff[sq_pkg::CFG_EN_BIT]
        |-> tx.squelch_req[3:0] == 4'hF && tx.power_req[3:0] == 4'hF)
        else $error("port A not squelched by 0x0F");
    en_bit_off_a: assert property (!cfg_a_ff[sq_pkg::CFG_EN_BIT] |-> ##2 tx_current_on[3:0] == 4'h0)
        else $error("current flows with enable bit low");
    hist_sticky_a: assert property (!commit_ff |=> (los_hist_ff & $past(los_hist_ff)) == $past(los_hist_ff))
        else $error("loss history bit dropped without a write");
    write_after_ack_a: assert property ($changed(sq_a_ff) |-> $past(commit_ff) && $past(ptr_ff) == sq_pkg::OFS_SQ_A)
        else $error("squelch register changed without an acknowledged write");
endmodule // i2c_slave_tx_squelch_ctrl

/* bench/i2c_master_model.sv */
// two-wire bus master model paced by its own link clock
`timescale 1ns/10ps
module i2c_master_model (
    input wire logic lclk,
    input wire logic sda_wire,
    output logic scl_out,
    output logic sda_low,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    // larger stretch gives a slower bus
    int stretch = 1;
    initial
    begin
        scl_out = 1'b1;
        sda_low = 1'b0;
        rd_data = 8'h00;
        rd_valid = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n * stretch) @(posedge lclk);
    endtask
    // data moves only while scl is low; the slave gets 4 link cycles to let go
    task automatic bitx(input logic b, output logic r);
        scl_out = 1'b0;
        tick(4);
        sda_low = ~b;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        r = sda_wire;
        tick(2);
    endtask
    task automatic start();
        scl_out = 1'b0;
        tick(4);
        sda_low = 1'b0;
        tick(2);
        scl_out = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
    endtask
    task automatic stop();
        scl_out = 1'b0;
        tick(4);
        sda_low = 1'b1;
        tick(2);
        scl_out = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic mbit, input logic rd, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], r[i]);
        end
        if (rd)
        begin
            rd_data = r;
            rd_valid = 1'b1;
        end
        bitx(mbit, a);
        rd_valid = 1'b0;
        ack = ~a;
    endtask
endmodule // i2c_master_model

/* bench/i2c_slave_tx_squelch_ctrl_tb.sv */
// self-checking bench for the serial control port and transmitter gating
`timescale 1ns/10ps
module i2c_slave_tx_squelch_ctrl_tb;
    logic ref_clk;
    logic lclk;
    logic rst;
    logic [1:0] addr_sel;
    logic [7:0] signal_loss_flag;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic sda_wire;
    logic [7:0] tx_powered;
    logic [7:0] tx_current_on;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [7:0] expq[$];
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    // open drain with pull-up
    assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_low;
    i2c_slave_tx_squelch_ctrl u_i2c_slave_tx_squelch_ctrl (
        .ref_clk(ref_clk),
        .rst(rst),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_sel(addr_sel),
        .signal_loss_flag(signal_loss_flag),
        .tx_powered(tx_powered),
        .tx_current_on(tx_current_on)
    );
    i2c_master_model u_i2c_master_model (
        .lclk(lclk),
        .sda_wire(sda_wire),
        .scl_out(scl),
        .sda_low(sda_low),
        .rd_data(rd_data),
        .rd_valid(rd_valid)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        lclk = 1'b0;
        #3.7;
        forever #6 lclk = ~lclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic [7:0] r;
        logic a;
        u_i2c_master_model.xfer(d, 1'b1, 1'b0, r, a);
        chk({7'h00, a}, {7'h00, exp_ack});
    endtask
    task automatic hdr(input logic [7:0] ptr);
        u_i2c_master_model.start();
        send({sq_pkg::ADDR_FIXED, addr_sel, 1'b0}, 1'b1);
        send(ptr, 1'b1);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        hdr(ptr);
        send(d, 1'b1);
        u_i2c_master_model.stop();
        wait_cyc(6);
    endtask
    task automatic raddr();
        u_i2c_master_model.start();
        send({sq_pkg::ADDR_FIXED, addr_sel, 1'b1}, 1'b1);
    endtask
    task automatic rbyte(input logic [7:0] exp, input logic mbit);
        logic [7:0] r;
        logic a;
        expq.push_back(exp);
        u_i2c_master_model.xfer(8'hFF, mbit, 1'b1, r, a);
    endtask
    // acked byte is sent again, then a fresh read address re-reads without a pointer
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        hdr(ptr);
        raddr();
        rbyte(exp, 1'b0);
        rbyte(exp, 1'b1);
        raddr();
        rbyte(exp, 1'b1);
        u_i2c_master_model.stop();
    endtask
    always @(posedge rd_valid)
    begin
        chk(rd_data, expq.pop_front());
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            final_report();
        end
    end
    initial
    begin
        logic [7:0] v;
        logic b;
        rst = 1'b1;
        addr_sel = 2'b00;
        signal_loss_flag = 8'h00;
        v = 8'($urandom(32'h4B12));
        wait_cyc(10);
        addr_sel <= 2'($urandom());
        rst <= 1'b0;
        wait_cyc(110);
        chk(tx_powered, 8'hFF);
        chk({7'h00, sda_out}, 8'h00);
        chk(tx_current_on, 8'hFF);
        rd(sq_pkg::OFS_SQ_A, sq_pkg::SQ_RESET);
        rd(sq_pkg::OFS_CFG_A, sq_pkg::CFG_RESET);
        wr(sq_pkg::OFS_SQ_A, 8'h0F);
        chk(tx_current_on, 8'hF0);
        chk(tx_powered, 8'hFF);
        rd(sq_pkg::OFS_SQ_A, 8'h0F);
        repeat (3)
        begin
            v = {4'($urandom_range(15, 1)), 4'($urandom_range(15, 1))};
            wr(sq_pkg::OFS_SQ_A, v);
            chk(tx_current_on, 8'hFF);
            chk(tx_powered, 8'hFF);
        end
        wr(sq_pkg::OFS_SQ_A, 8'hF0);
        chk(tx_powered, 8'hF0);
        chk(tx_current_on, 8'hF0);
        wr(sq_pkg::OFS_SQ_A, 8'hFF);
        chk(tx_powered, 8'hF0);
        wait_cyc(100);
        chk(tx_powered, 8'hFF);
        chk(tx_current_on, 8'hFF);
        wr(sq_pkg::OFS_CFG_B, 8'h00);
        chk(tx_powered, 8'h0F);
        wr(sq_pkg::OFS_CFG_B, sq_pkg::CFG_RESET);
        wr(sq_pkg::OFS_CFG_A, 8'h00);
        chk(tx_powered, 8'hF0);
        chk(tx_current_on, 8'hF0);
        wr(sq_pkg::OFS_CFG_A, sq_pkg::CFG_RESET);
        // other straps: nothing acked, nothing stored
        u_i2c_master_model.start();
        send({sq_pkg::ADDR_FIXED, ~addr_sel, 1'b0}, 1'b0);
        send(sq_pkg::OFS_SQ_A, 1'b0);
        send(8'h00, 1'b0);
        u_i2c_master_model.stop();
        rd(sq_pkg::OFS_SQ_A, 8'hFF);
        hdr(sq_pkg::OFS_SQ_B);
        repeat (4) u_i2c_master_model.bitx(1'b0, b);
        u_i2c_master_model.stop();
        rd(sq_pkg::OFS_SQ_B, 8'hFF);
        u_i2c_master_model.stretch = 6;
        wr(sq_pkg::OFS_SQ_B, 8'h0F);
        chk(tx_current_on, 8'h0F);
        rd(sq_pkg::OFS_SQ_B, 8'h0F);
        u_i2c_master_model.stretch = 1;
        @(posedge ref_clk);
        signal_loss_flag <= 8'h01;
        wait_cyc(10);
        signal_loss_flag <= 8'h00;
        wait_cyc(10);
        rd(sq_pkg::OFS_LOS_A, 8'h10);
        wr(sq_pkg::OFS_LOS_A, 8'h00);
        rd(sq_pkg::OFS_LOS_A, 8'h00);
        rd(8'h55, sq_pkg::UNMAPPED_READ);
        wait_cyc(20);
        final_report();
    end
endmodule // i2c_slave_tx_squelch_ctrl_tb
